//--- src/rcsr_pkg.sv
package rcsr_pkg;

  // register byte addresses on the 12-bit apb address
  localparam logic [11:0] ADDR_CAUSE    = 12'hff0;  // read: cause flags, write: watchdog ctl
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h100;  // sticky event bits, write one to clear
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h104;  // event enables

  // field positions inside the cause byte
  localparam int POS_POWER_ON = 7;
  localparam int POS_SLEEP    = 6;
  localparam int POS_WDOG     = 5;
  localparam int POS_PIN      = 4;
  localparam int POS_LOW_VOLT = 0;

  // cause flags, packed as {power_on, sleep_recovery, watchdog_timeout, pin_reset}
  localparam logic [3:0] CAUSE_POWER_ON  = 4'h8;
  localparam logic [3:0] CAUSE_PIN       = 4'h1;
  localparam logic [3:0] CAUSE_WDOG_RUN  = 4'h2;
  localparam logic [3:0] CAUSE_WDOG_STOP = 4'h6;
  localparam logic [3:0] CAUSE_GPIO_STOP = 4'h4;

  // event index in the interrupt status and mask registers
  localparam int NUM_EVT       = 7;
  localparam int EVT_POWER_ON  = 0;
  localparam int EVT_PIN       = 1;
  localparam int EVT_WDOG_RUN  = 2;
  localparam int EVT_DBG_CTL   = 3;
  localparam int EVT_DBG_PIN   = 4;
  localparam int EVT_GPIO_STOP = 5;
  localparam int EVT_WDOG_STOP = 6;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcsr_apb_req_s;

  // one-cycle pulses from the reset and recovery sources
  typedef struct packed {
    logic power_on;   // power-on reset
    logic pin_reset;  // external reset pin
    logic wdog_tmo;   // watchdog time-out, stop or run decided by in_stop
    logic dbg_ctl;    // debugger control bit reset
    logic dbg_pin;    // debug_pin low out of stop
    logic gpio_stop;  // gpio transition recovery from stop
  } rcsr_events_s;

  // complete state of the block
  typedef struct packed {
    logic [3:0]         flags;     // power_on, sleep_recovery, watchdog_timeout, pin_reset
    logic [3:0]         snap;      // flags returned by a pending read
    logic [7:0]         rdata;     // read data held for the access phase
    logic               slverr;    // unmapped address seen at setup
    logic [NUM_EVT-1:0] irq_stat;  // sticky event bits
    logic [NUM_EVT-1:0] irq_mask;  // event enables
    logic               irq;       // registered interrupt level
    logic               wdc_wr;    // watchdog control write strobe
    logic [7:0]         wdc_data;  // watchdog control write data
  } rcsr_state_s;

  localparam rcsr_state_s STATE_RESET = '{flags: CAUSE_POWER_ON, default: '0};

endpackage

//--- src/rcsr_top.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// RULE_01: cause reads at ff0, writes go to watchdog
// RULE_02: eight bits: por, stop, wdt, pin, lvd
// RULE_03: power-on sets only the power-on flag
// RULE_04: watchdog or stop recovery clears power-on
// RULE_05: reading clears power-on after it returns
// RULE_06: stop recovery sets sleep flag, wdt tells cause
// RULE_07: sleep flag cleared by por, running wdt
// RULE_08: reading clears sleep recovery flag
// RULE_09: wdt flag cleared by por, gpio, read
// RULE_10: software reads cause before clearing wdt irq
// RULE_11: pin reset sets pin flag, cleared likewise
// RULE_12: low voltage bit is live, never latched
// RULE_13: debugger control reset leaves only power-on
// RULE_14: debug pin stop reset leaves only power-on
// RULE_15: gpio stop recovery sets only sleep flag
// RULE_16: stop watchdog recovery sets sleep and wdt
// RULE_17: running watchdog reset sets only wdt
// RULE_18: reset pin sets only pin flag
// RULE_19: reserved bits read zero, writes change nothing
module rcsr_top (
  input  wire logic                  clk,        // system clock, 100 mhz
  input  wire logic                  rst,        // synchronous reset, treated as power-on
  input  wire logic                  psel,       // apb select
  input  wire logic                  penable,    // apb enable
  input  wire logic                  pwrite,     // apb direction, 1 = write
  input  wire logic [11:0]           paddr,      // apb byte address
  input  wire logic [31:0]           pwdata,     // apb write data
  output logic      [31:0]           prdata,     // apb read data
  output logic                       pready,     // apb ready
  output logic                       pslverr,    // apb error on unmapped address
  input  wire rcsr_pkg::rcsr_events_s evt,       // reset and recovery pulses
  input  wire logic                  in_stop,    // part is in stop mode
  input  wire logic                  low_volt,   // live low-voltage comparator
  output logic                       wdc_wr,     // watchdog control write pulse
  output logic      [7:0]            wdc_data,   // watchdog control write data
  output logic      [3:0]            cause_flags,// current cause flags
  output logic                       irq         // interrupt level
);

  // cause value for this cycle's events; bit 4 says whether any event hit
  function automatic logic [4:0] cause_of(input rcsr_pkg::rcsr_events_s e, input logic stop);
    logic [4:0] c;
    c = 5'h00;
    if (e.power_on) begin
      c = {1'b1, rcsr_pkg::CAUSE_POWER_ON};           // see RULE_03
    end else if (e.pin_reset) begin
      c = {1'b1, rcsr_pkg::CAUSE_PIN};                // see RULE_18, see RULE_11
    end else if (e.dbg_ctl) begin
      c = {1'b1, rcsr_pkg::CAUSE_POWER_ON};           // see RULE_13
    end else if (e.dbg_pin) begin
      c = {1'b1, rcsr_pkg::CAUSE_POWER_ON};           // see RULE_14
    end else if (e.wdog_tmo && stop) begin
      c = {1'b1, rcsr_pkg::CAUSE_WDOG_STOP};          // see RULE_16, see RULE_06, see RULE_04
    end else if (e.wdog_tmo) begin
      c = {1'b1, rcsr_pkg::CAUSE_WDOG_RUN};           // see RULE_17, see RULE_07, see RULE_04
    end else if (e.gpio_stop) begin
      c = {1'b1, rcsr_pkg::CAUSE_GPIO_STOP};          // see RULE_15, see RULE_09
    end
    return c;
  endfunction

  // one bit per event for the interrupt status register
  function automatic logic [rcsr_pkg::NUM_EVT-1:0] evt_vec(input rcsr_pkg::rcsr_events_s e,
                                                            input logic stop);
    logic [rcsr_pkg::NUM_EVT-1:0] v;
    v = '0;
    v[rcsr_pkg::EVT_POWER_ON]  = e.power_on;
    v[rcsr_pkg::EVT_PIN]       = e.pin_reset;
    v[rcsr_pkg::EVT_WDOG_RUN]  = e.wdog_tmo & ~stop;
    v[rcsr_pkg::EVT_DBG_CTL]   = e.dbg_ctl;
    v[rcsr_pkg::EVT_DBG_PIN]   = e.dbg_pin;
    v[rcsr_pkg::EVT_GPIO_STOP] = e.gpio_stop;
    v[rcsr_pkg::EVT_WDOG_STOP] = e.wdog_tmo & stop;
    return v;
  endfunction

  // address decode, used for setup and access phases alike
  function automatic logic [2:0] decode(input logic [11:0] a);
    return {a == rcsr_pkg::ADDR_IRQ_MASK, a == rcsr_pkg::ADDR_IRQ_STAT,
            a == rcsr_pkg::ADDR_CAUSE};
  endfunction

  rcsr_pkg::rcsr_state_s          s_q;
  rcsr_pkg::rcsr_state_s          s_d;
  rcsr_pkg::rcsr_apb_req_s        req;
  logic                           setup;
  logic                           access;
  logic [2:0]                     hit;
  logic [4:0]                     cause;
  logic [rcsr_pkg::NUM_EVT-1:0]   ev;

  assign req    = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign setup  = req.psel & ~req.penable;
  assign access = req.psel & req.penable;
  assign hit    = decode(req.paddr);
  assign cause  = cause_of(evt, in_stop);
  assign ev     = evt_vec(evt, in_stop);

  // next-state logic: bus first, then events, so a set in the same cycle as a clear wins
  always_comb begin
    s_d        = s_q;
    s_d.wdc_wr = 1'b0;
    if (setup) begin
      // sample read data early so data comes from flops; zero-wait access phase follows
      s_d.slverr = ~|hit;
      s_d.snap   = 4'h0;
      s_d.rdata  = 8'h00;
      if (!req.pwrite && hit[0]) begin
        // bit placement from the package; reserved bits keep the zero set above
        s_d.rdata[rcsr_pkg::POS_POWER_ON] = s_q.flags[3];    // see RULE_02
        s_d.rdata[rcsr_pkg::POS_SLEEP]    = s_q.flags[2];
        s_d.rdata[rcsr_pkg::POS_WDOG]     = s_q.flags[1];
        s_d.rdata[rcsr_pkg::POS_PIN]      = s_q.flags[0];
        s_d.rdata[rcsr_pkg::POS_LOW_VOLT] = low_volt;        // see RULE_12, see RULE_19
        s_d.snap  = s_q.flags;
      end else if (!req.pwrite && hit[1]) begin
        s_d.rdata = 8'(s_q.irq_stat);
      end else if (!req.pwrite && hit[2]) begin
        s_d.rdata = 8'(s_q.irq_mask);
      end
    end
    if (access) begin
      if (!req.pwrite && hit[0]) begin
        // clear only what the read returned; anything set since stays for the next read
        s_d.flags = s_q.flags & ~s_q.snap;            // see RULE_05, see RULE_08, see RULE_09
      end
      if (req.pwrite && hit[0]) begin
        s_d.wdc_wr   = 1'b1;                          // see RULE_01
        s_d.wdc_data = req.pwdata[7:0];
      end
      if (req.pwrite && hit[1]) begin
        s_d.irq_stat = s_q.irq_stat & ~req.pwdata[rcsr_pkg::NUM_EVT-1:0];
      end
      if (req.pwrite && hit[2]) begin
        s_d.irq_mask = req.pwdata[rcsr_pkg::NUM_EVT-1:0];
      end
      s_d.snap = 4'h0;
    end
    // reset and recovery events overwrite the whole cause set
    if (cause[4]) begin
      s_d.flags = cause[3:0];                         // see RULE_03, see RULE_11
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= rcsr_pkg::STATE_RESET;                   // see RULE_03
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; upper read bits are always zero
  assign prdata      = {24'h000000, s_q.rdata};       // see RULE_19
  assign pready      = access;
  assign pslverr     = access & s_q.slverr;
  assign wdc_wr      = s_q.wdc_wr;
  assign wdc_data    = s_q.wdc_data;
  assign cause_flags = s_q.flags;
  assign irq         = s_q.irq;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // bus phases on the cause address, decoded here from the pins and the map constants
  logic cause_read;
  logic cause_write;
  logic cause_setup;
  logic no_evt;
  logic no_higher;
  logic mapped;
  assign cause_setup = setup && !pwrite && paddr == rcsr_pkg::ADDR_CAUSE;
  assign cause_read  = access && !pwrite && paddr == rcsr_pkg::ADDR_CAUSE;
  assign cause_write = access && pwrite && paddr == rcsr_pkg::ADDR_CAUSE;
  // a quiet cycle, so a clear check is not hidden behind a fresh cause
  assign no_evt      = evt == '0;
  // nothing that outranks the watchdog and gpio recoveries
  assign no_higher   = !evt.power_on && !evt.pin_reset && !evt.dbg_ctl && !evt.dbg_pin;
  // map from the address constants, independent of the decode function
  assign mapped      = paddr == rcsr_pkg::ADDR_CAUSE || paddr == rcsr_pkg::ADDR_IRQ_STAT ||
                       paddr == rcsr_pkg::ADDR_IRQ_MASK;

  // reset leaves the power-on cause and quiet strobes on the release edge
  a_reset_state: assert property ($fell(rst) // see RULE_03
                                  |-> cause_flags == 4'h8 && !wdc_wr && !irq)
    else $error("reset did not leave the power-on cause");

  // power-on wins over every other cause in the same cycle
  a_por_cause: assert property (evt.power_on // see RULE_03
                                |=> cause_flags == 4'h8)
    else $error("power-on did not leave only the power-on flag");

  // external pin reset
  a_pin_cause: assert property (evt.pin_reset && !evt.power_on // see RULE_18
                                |=> cause_flags == 4'h1)
    else $error("pin reset did not leave only the pin flag");

  // debugger control bit reset
  a_dbg_ctl_cause: assert property (evt.dbg_ctl && !evt.power_on // see RULE_13
                                    && !evt.pin_reset |=> cause_flags == 4'h8)
    else $error("debugger control reset did not leave only power-on");

  // debug pin driven low out of stop
  a_dbg_pin_cause: assert property (evt.dbg_pin && !evt.dbg_ctl && !evt.power_on // see RULE_14
                                    && !evt.pin_reset |=> cause_flags == 4'h8)
    else $error("debug pin reset did not leave only power-on");

  // watchdog time-out in stop is a stop recovery
  a_wdog_stop: assert property (evt.wdog_tmo && in_stop && no_higher // see RULE_16
                                |=> cause_flags == 4'h6)
    else $error("stop watchdog recovery flags wrong");

  // watchdog time-out while running is a full reset
  a_wdog_run: assert property (evt.wdog_tmo && !in_stop && no_higher // see RULE_17
                               |=> cause_flags == 4'h2)
    else $error("running watchdog reset flags wrong");

  // gpio transition out of stop
  a_gpio_stop: assert property (evt.gpio_stop && !evt.wdog_tmo && no_higher // see RULE_15
                                |=> cause_flags == 4'h4)
    else $error("gpio stop recovery flags wrong");

  // power-on flag dropped by any watchdog or stop recovery
  a_por_cleared: assert property ((evt.wdog_tmo || evt.gpio_stop) && no_higher // see RULE_04
                                  |=> !cause_flags[3])
    else $error("power-on flag survived a watchdog or stop recovery");

  // sleep flag marks every stop recovery
  a_sleep_set: assert property (no_higher // see RULE_06
                                && (evt.gpio_stop || evt.wdog_tmo && in_stop)
                                |=> cause_flags[2])
    else $error("stop recovery did not set the sleep flag");

  // sleep without the watchdog flag means another wake-up source
  a_sleep_source: assert property (evt.gpio_stop && !evt.wdog_tmo && no_higher // see RULE_06
                                   |=> cause_flags[2] && !cause_flags[1])
    else $error("gpio recovery reported as watchdog recovery");

  // sleep flag dropped by power-on or a running watchdog reset
  a_sleep_cleared: assert property (evt.power_on // see RULE_07
                                    || evt.wdog_tmo && !in_stop && no_higher
                                    |=> !cause_flags[2])
    else $error("sleep flag survived power-on or running watchdog");

  // watchdog flag dropped by power-on or a pin-change recovery
  a_wdog_cleared: assert property (evt.power_on // see RULE_09
                                   || evt.gpio_stop && !evt.wdog_tmo && no_higher
                                   |=> !cause_flags[1])
    else $error("watchdog flag survived power-on or gpio recovery");

  // pin flag dropped by power-on or a pin-change recovery
  a_pin_cleared: assert property (evt.power_on // see RULE_11
                                  || evt.gpio_stop && !evt.wdog_tmo && no_higher
                                  |=> !cause_flags[0])
    else $error("pin flag survived power-on or gpio recovery");

  // a read clears what it returned; the byte stands on prdata in the access cycle
  a_read_clears: assert property (cause_read && no_evt // see RULE_05
                                  |=> (cause_flags & $past(prdata[7:4])) == 4'h0)
    else $error("cause read did not clear returned flags");

  // power-on flag cleared once returned
  a_read_por: assert property (cause_read && no_evt && prdata[7] // see RULE_05
                               |=> !cause_flags[3])
    else $error("read left the power-on flag set");

  // sleep flag cleared once returned
  a_read_sleep: assert property (cause_read && no_evt && prdata[6] // see RULE_08
                                 |=> !cause_flags[2])
    else $error("read left the sleep flag set");

  // watchdog flag cleared once returned
  a_read_wdog: assert property (cause_read && no_evt && prdata[5] // see RULE_09
                                |=> !cause_flags[1])
    else $error("read left the watchdog flag set");

  // pin flag cleared once returned
  a_read_pin: assert property (cause_read && no_evt && prdata[4] // see RULE_11
                               |=> !cause_flags[0])
    else $error("read left the pin flag set");

  // a write at the cause address reaches the watchdog only
  a_write_ignored: assert property (cause_write && no_evt // see RULE_01
                                    |=> $stable(cause_flags) && wdc_wr
                                    && wdc_data == $past(pwdata[7:0]))
    else $error("write to cause address changed flags or missed watchdog");

  // the watchdog strobe comes only from a completed write there
  a_wdc_source: assert property (wdc_wr // see RULE_01
                                 |-> $past(cause_write))
    else $error("watchdog strobe without a write");

  // one cycle per write; back-to-back writes still have a setup cycle between
  a_wdc_single: assert property (wdc_wr // see RULE_01
                                 |=> !wdc_wr)
    else $error("watchdog strobe longer than one cycle");

  // read data carries the flags seen at setup
  a_read_value: assert property (cause_setup // see RULE_02
                                 |=> prdata[7:4] == $past(cause_flags))
    else $error("cause read returned wrong flags");

  // low voltage bit follows the comparator, not a stored copy
  a_lvd_live: assert property (cause_setup // see RULE_12
                               |=> prdata[0] == $past(low_volt))
    else $error("low voltage bit not live");

  // reserved and upper bits of the cause word stay zero
  a_rsvd_zero: assert property (cause_setup // see RULE_19
                                |=> prdata[3:1] == 3'b000 && prdata[31:8] == 24'h000000)
    else $error("reserved bits of the cause word set");

  // unmapped address: error and zero data
  a_unmapped_err: assert property (access && !mapped
                                   |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  // mapped address: zero-wait answer without error
  a_mapped_ok: assert property (access && mapped // see RULE_01
                                |-> pready && !pslverr)
    else $error("mapped access refused or delayed");

  // read data stands past the access cycle until the next setup
  a_read_stands: assert property (access
                                  |=> $stable(prdata))
    else $error("read data changed outside a setup edge");

  // an unmasked event raises the interrupt one cycle later
  a_irq_raise: assert property ((ev & s_q.irq_mask) != '0 && !(access && pwrite)
                                |=> irq)
    else $error("unmasked event did not raise interrupt");

  // without events or writes the interrupt cannot rise
  a_irq_quiet: assert property (!irq && no_evt && !(access && pwrite)
                                |=> !irq)
    else $error("interrupt rose without an event");

  // main scenarios
  c_read_after_por: cover property (evt.power_on ##[1:8] cause_read);
  c_wdog_stop:      cover property (evt.wdog_tmo && in_stop ##[1:20] cause_read);
  c_set_and_clear:  cover property (cause_read && cause[4]);
  c_irq:            cover property (!irq ##1 irq);

endmodule

//--- verif/rcsr_src_model.sv
`timescale 1ns/1ps
// reset and recovery sources: one clean pulse per cause, never two causes at once
module rcsr_src_model (
  input  wire logic              clk,     // system clock
  output rcsr_pkg::rcsr_events_s evt,     // cause pulses
  output logic                   in_stop  // part in stop mode
);
  initial begin
    evt = '0;
    in_stop = 1'b0;
  end
  // kind: 1 por, 2 pin, 3 wdog run, 4 wdog stop, 5 dbg ctl, 6 dbg pin, 7 gpio stop
  task automatic fire(input int kind);
    rcsr_pkg::rcsr_events_s e;
    e = '0;
    e.power_on  = (kind == 1);
    e.pin_reset = (kind == 2);
    e.wdog_tmo  = (kind == 3) || (kind == 4);
    e.dbg_ctl   = (kind == 5);
    e.dbg_pin   = (kind == 6);
    e.gpio_stop = (kind == 7);
    @(posedge clk);
    evt <= e;
    // stop level must stand with the pulse, it decides stop versus run time-out
    in_stop <= (kind == 4) || (kind == 6) || (kind == 7);
    @(posedge clk);
    evt <= '0;
    in_stop <= 1'b0;
  endtask
endmodule

//--- verif/rcsr_tb.sv
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, psel, penable, pwrite, low_volt, pready, pslverr, wdc_wr, irq, in_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  wdc_data;
  logic [3:0]  cause_flags;
  logic        err;
  rcsr_pkg::rcsr_events_s evt;
  int          n_mismatch, check_count;
  logic [7:0]  exp_of [8] = '{8'h00, 8'h80, 8'h10, 8'h20, 8'h60, 8'h80, 8'h80, 8'h40};
  int          pa [6] = '{1, 1, 4, 2, 3, 4};
  int          pb [6] = '{7, 4, 3, 7, 7, 1};

  rcsr_top u_rcsr_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .in_stop(in_stop), .low_volt(low_volt), .wdc_wr(wdc_wr), .wdc_data(wdc_data),
    .cause_flags(cause_flags), .irq(irq));
  rcsr_src_model u_rcsr_src_model (.clk(clk), .evt(evt), .in_stop(in_stop));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer, request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; a hang is ended by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    {rst, psel, penable, pwrite, low_volt} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h80);
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h00);
    // every cause alone, then the read must have cleared it
    for (int k = 1; k < 8; k++) begin
      u_rcsr_src_model.fire(k);
      #1;
      chk(32'(cause_flags), {28'h0, exp_of[k][7:4]}, "cause flags");
      rd_chk(rcsr_pkg::ADDR_CAUSE, {24'h0, exp_of[k]});
      rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h00);
    end
    // a later cause must wipe the flags the earlier one left
    for (int i = 0; i < 6; i++) begin
      u_rcsr_src_model.fire(pa[i]);
      u_rcsr_src_model.fire(pb[i]);
      rd_chk(rcsr_pkg::ADDR_CAUSE, {24'h0, exp_of[pb[i]]});
    end
    low_volt <= 1'b1;
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h01);
    low_volt <= 1'b0;
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h00);
    // a write to the cause address goes to the watchdog only
    u_rcsr_src_model.fire(2);
    apb(1'b1, rcsr_pkg::ADDR_CAUSE, 32'h55);
    #1;
    chk(32'(wdc_wr), 32'h1, "wdc strobe");
    chk(32'(wdc_data), 32'h55, "wdc data");
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h10);
    apb(1'b0, 12'h200, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // interrupt: clear, mask to pin reset only, masked and unmasked events
    apb(1'b1, rcsr_pkg::ADDR_IRQ_STAT, 32'h7f);
    apb(1'b1, rcsr_pkg::ADDR_IRQ_MASK, 32'h02);
    rd_chk(rcsr_pkg::ADDR_IRQ_MASK, 32'h02);
    u_rcsr_src_model.fire(7);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0, "masked irq");
    rd_chk(rcsr_pkg::ADDR_IRQ_STAT, 32'h20);
    u_rcsr_src_model.fire(2);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h1, "irq raised");
    rd_chk(rcsr_pkg::ADDR_CAUSE, 32'h10);
    apb(1'b1, rcsr_pkg::ADDR_IRQ_STAT, 32'h02);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0, "irq cleared");
    rd_chk(rcsr_pkg::ADDR_IRQ_STAT, 32'h20);
    test_done();
  end
endmodule
